// ==== pkg/ea_pkg.sv ====
package ea_pkg;

    // Data path widths
    localparam int DATA_W  = 16;
    localparam int FADDR_W = 13;
    localparam int IDX_W   = 4;
    localparam int PCHI_W  = 7;
    localparam int SLB_W   = 8;
    localparam int MOD_W   = 5;
    localparam int LIT5_W  = 5;
    localparam int LIT10_W = 10;

    // Stack constants
    localparam logic [15:0] STACK_FLOOR = 16'h0800;
    localparam logic [15:0] SP_RESET    = 16'h0800;
    localparam logic [15:0] WORD_STEP   = 16'h0002;
    localparam logic [3:0]  SP_IDX      = 4'hf;
    localparam logic [3:0]  WREG0_IDX   = 4'h0;

    // Secure RAM windows, inclusive bounds
    localparam logic [15:0] BOOT_RAM_LO = 16'h0800;
    localparam logic [15:0] BOOT_RAM_HI = 16'h087f;
    localparam logic [15:0] SEC_RAM_LO  = 16'h0880;
    localparam logic [15:0] SEC_RAM_HI  = 16'h08ff;

    typedef enum logic [2:0] {
        MODE_FILE,
        MODE_DIRECT,
        MODE_IND,
        MODE_POST,
        MODE_PRE,
        MODE_INDEXED,
        MODE_LITOFF
    } addr_mode_t;

    typedef enum logic [2:0] {
        STK_NONE,
        STK_PUSH_DATA,
        STK_PUSH_CALL,
        STK_PUSH_EXC,
        STK_POP
    } stack_op_t;

    typedef enum logic [1:0] {
        SEG_GENERAL,
        SEG_BOOT,
        SEG_SECURE
    } exec_seg_t;

    typedef enum logic [1:0] {
        OP2_DEFAULT_WORKING_REG,
        OP2_MEM,
        OP2_LIT
    } op2_src_t;

endpackage

// ==== pkg/guard_if.sv ====
`timescale 1ns/100ps
interface guard_if;
    logic [15:0] ea;
    logic [15:0] limit;
    logic        check;
    logic        over;
    logic        under;

    modport owner (
        output ea,
        output limit,
        output check,
        input  over,
        input  under
    );

    modport guard (
        input  ea,
        input  limit,
        input  check,
        output over,
        output under
    );
endinterface

// ==== rtl/stack_guard.sv ====
`timescale 1ns/100ps
module stack_guard (
    // Comparison channel
    guard_if.guard g
);

    // Equal to the limit is still legal, only beyond it traps
    assign g.over  = g.check && (g.ea > g.limit);       // R7 R8
    // Floor keeps the stack out of the register space
    assign g.under = g.check && (g.ea < ea_pkg::STACK_FLOOR); // R9

endmodule

// ==== rtl/stack_limit_and_ea_generation.sv ====
`timescale 1ns/100ps
// Behaviour
// R1 - A working register serves as stack pointer, pointing at first free word, growing up.
// R2 - Push writes at the pointer then increments; pop decrements first then reads.
// R3 - Call pushes program counter upper byte with its top bit cleared.
// R4 - Exception push places status low byte beside the program counter upper byte.
// R5 - Stack limit register is never initialised by reset.
// R6 - Bit 0 of stack limit and stack pointer always reads zero.
// R7 - Every stack pointer based address is compared against the stack limit.
// R8 - Push at pointer equal to limit is fine; the next push traps.
// R9 - Stack pointer address below 0x0800 raises the stack error trap.
// R10 - Software avoids stack indirect read right after writing the stack limit.
// R11 - Boot secure RAM is reachable only from boot flash code when enabled.
// R12 - Secure segment RAM is reachable only from secure flash code when enabled.
// R13 - File register instructions use a 13-bit direct address, first 8192 bytes.
// R14 - File register instructions default to working register zero for results.
// R15 - Operand one comes direct from base register; operand two from register, memory, literal.
// R16 - Register indirect uses the pointer unmodified as the address.
// R17 - Post-modified uses the pointer, then writes back pointer plus constant.
// R18 - Pre-modified adds a signed constant first, uses and keeps the result.
// R19 - Indexed address is pointer plus base register.
// R20 - Literal offset address is pointer plus instruction literal.
// R21 - General literals come in 5-bit and 10-bit widths by format.
// R22 - Stack error trap is a one-cycle request alongside the compared address.
module stack_limit_and_ea_generation (
    // Clock and reset
    input  wire logic                   mclk_i,
    input  wire logic                   reset_i,
    // Addressing request
    input  wire logic                   req_valid_i,
    input  wire ea_pkg::addr_mode_t     mode_i,
    input  wire logic [3:0]             ptr_idx_i,
    input  wire logic [15:0]            ptr_val_i,
    input  wire logic [15:0]            base_val_i,
    input  wire logic [4:0]             mod_const_i,
    input  wire logic [15:0]            lit_offset_i,
    input  wire logic [12:0]            file_addr_i,
    input  wire logic                   is_write_i,
    input  wire logic [15:0]            wdata_i,
    // Result destination
    input  wire logic                   dst_default_working_reg_i,
    input  wire logic [3:0]             dst_idx_i,
    // Second operand
    input  wire ea_pkg::op2_src_t       op2_src_i,
    input  wire logic [15:0]            op2_reg_i,
    input  wire logic [15:0]            op2_mem_i,
    input  wire logic                   lit_long_i,
    input  wire logic [9:0]             lit_i,
    // Stack operations
    input  wire ea_pkg::stack_op_t      stack_op_i,
    input  wire logic [6:0]             pc_hi_i,
    input  wire logic [7:0]             status_low_byte_i,
    // Direct register writes
    input  wire logic                   sp_wr_i,
    input  wire logic [15:0]            sp_wdata_i,
    input  wire logic                   limit_wr_i,
    input  wire logic [15:0]            limit_wdata_i,
    // Code segment security
    input  wire ea_pkg::exec_seg_t      exec_seg_i,
    input  wire logic                   boot_ram_en_i,
    input  wire logic                   secure_ram_en_i,
    // Memory port
    output logic                        mem_req_o,
    output logic                        mem_we_o,
    output logic [15:0]                 ea_o,
    output logic [15:0]                 mem_wdata_o,
    // Pointer write back
    output logic                        wb_valid_o,
    output logic [3:0]                  wb_idx_o,
    output logic [15:0]                 wb_data_o,
    // Operands and destination
    output logic [15:0]                 op1_o,
    output logic [15:0]                 op2_o,
    output logic [3:0]                  dst_idx_o,
    output logic                        dst_is_default_working_reg_o,
    // Status
    output logic                        stack_trap_o,
    output logic                        secure_block_o,
    output logic [15:0]                 sp_o
);

    // State
    logic [15:0] sp_ff;
    logic [15:0] limit_ff;
    logic [15:0] nxt_sp;

    // Registered outputs
    logic        mem_req_ff;
    logic        mem_we_ff;
    logic [15:0] ea_ff;
    logic [15:0] mem_wdata_ff;
    logic        wb_valid_ff;
    logic [3:0]  wb_idx_ff;
    logic [15:0] wb_data_ff;
    logic [15:0] op1_ff;
    logic [15:0] op2_ff;
    logic [3:0]  dst_idx_ff;
    logic        dst_is_default_working_reg_ff;
    logic        trap_ff;
    logic        block_ff;

    // Decode wires
    wire         is_stack;
    wire         is_push;
    wire         is_pop;
    wire         req_live;
    wire         ptr_is_sp;
    wire         mode_mem;
    wire         mode_indirect;
    wire         mem_access;
    wire [15:0]  ptr_eff;
    wire [15:0]  mod_ext;
    wire [15:0]  ptr_mod;
    wire [15:0]  sp_up;
    wire [15:0]  sp_dn;
    wire [15:0]  mode_ea;
    wire [15:0]  ea_calc;
    wire [15:0]  push_word;
    wire         sp_based;
    wire         trap;
    wire         in_boot_ram;
    wire         in_sec_ram;
    wire         boot_deny;
    wire         sec_deny;
    wire         blocked;
    wire         go;
    wire         wb_needed;
    wire [3:0]   wb_idx;
    wire [15:0]  wb_data;
    wire         wb_fire;
    wire [15:0]  lit_ext;
    wire [15:0]  op2_sel;

    guard_if g ();

    // Limit and floor comparison
    stack_guard u_stack_guard (
        .g (g.guard)
    );

    // Request classification; a stack op overrides the mode field
    assign is_stack  = (stack_op_i != ea_pkg::STK_NONE);
    assign is_pop    = (stack_op_i == ea_pkg::STK_POP);
    assign is_push   = is_stack && !is_pop;
    assign req_live  = req_valid_i || is_stack;
    assign ptr_is_sp = (ptr_idx_i == ea_pkg::SP_IDX);

    assign mode_indirect = (mode_i == ea_pkg::MODE_IND)
                        || (mode_i == ea_pkg::MODE_POST)
                        || (mode_i == ea_pkg::MODE_PRE)
                        || (mode_i == ea_pkg::MODE_INDEXED)
                        || (mode_i == ea_pkg::MODE_LITOFF);
    assign mode_mem   = mode_indirect || (mode_i == ea_pkg::MODE_FILE);
    assign mem_access = is_stack || (req_valid_i && mode_mem);

    // Pointer source; the stack pointer lives here, not in the file
    assign ptr_eff = ptr_is_sp ? sp_ff : ptr_val_i;                    // R1
    assign mod_ext = {{(ea_pkg::DATA_W - ea_pkg::MOD_W){mod_const_i[4]}}, mod_const_i};
    assign ptr_mod = ptr_eff + mod_ext;
    assign sp_up   = sp_ff + ea_pkg::WORD_STEP;
    assign sp_dn   = sp_ff - ea_pkg::WORD_STEP;

    // Effective address per mode
    assign mode_ea =
        (mode_i == ea_pkg::MODE_FILE)    ? {3'h0, file_addr_i} :         // R13
        (mode_i == ea_pkg::MODE_IND)     ? ptr_eff :                     // R16
        (mode_i == ea_pkg::MODE_POST)    ? ptr_eff :                     // R17
        (mode_i == ea_pkg::MODE_PRE)     ? ptr_mod :                     // R18
        (mode_i == ea_pkg::MODE_INDEXED) ? ptr_eff + base_val_i :        // R19
        (mode_i == ea_pkg::MODE_LITOFF)  ? ptr_eff + lit_offset_i :      // R20
                                           16'h0000;

    // Push uses the pointer as is, pop uses it already decremented
    assign ea_calc = is_pop   ? sp_dn :                                 // R2
                     is_stack ? sp_ff : mode_ea;

    // Program counter upper word for call and exception pushes
    assign push_word =
        (stack_op_i == ea_pkg::STK_PUSH_CALL) ? {8'h00, 1'b0, pc_hi_i} :              // R3
        (stack_op_i == ea_pkg::STK_PUSH_EXC)  ? {status_low_byte_i, 1'b0, pc_hi_i} :  // R4
                                                wdata_i;

    // Any address built from the stack pointer is checked
    assign sp_based = is_stack || (req_valid_i && mode_indirect && ptr_is_sp);  // R7
    assign g.ea     = ea_calc;
    assign g.limit  = limit_ff;
    assign g.check  = sp_based;
    assign trap     = g.over || g.under;                                // R8 R9

    // Secure RAM windows gated by the executing segment
    assign in_boot_ram = (ea_calc >= ea_pkg::BOOT_RAM_LO) && (ea_calc <= ea_pkg::BOOT_RAM_HI);
    assign in_sec_ram  = (ea_calc >= ea_pkg::SEC_RAM_LO) && (ea_calc <= ea_pkg::SEC_RAM_HI);
    assign boot_deny   = boot_ram_en_i && in_boot_ram
                      && (exec_seg_i != ea_pkg::SEG_BOOT);              // R11
    assign sec_deny    = secure_ram_en_i && in_sec_ram
                      && (exec_seg_i != ea_pkg::SEG_SECURE);            // R12
    assign blocked     = mem_access && (boot_deny || sec_deny);

    // A trapped or blocked access neither reaches memory nor moves a pointer
    assign go = mem_access && !trap && !blocked;

    // Pointer write back for modifying modes and stack ops
    assign wb_needed = is_stack
                    || (req_valid_i && ((mode_i == ea_pkg::MODE_POST)
                                     || (mode_i == ea_pkg::MODE_PRE)));
    assign wb_idx  = is_stack ? ea_pkg::SP_IDX : ptr_idx_i;
    assign wb_data = is_push ? sp_up :                                  // R2
                     is_pop  ? sp_dn : ptr_mod;                         // R17 R18
    assign wb_fire = wb_needed && go;

    // Next stack pointer; own update wins over a decoder write
    assign nxt_sp = (wb_fire && (wb_idx == ea_pkg::SP_IDX))
                  ? {wb_data[15:1], 1'b0}                               // R6
                  : sp_wr_i ? {sp_wdata_i[15:1], 1'b0} : sp_ff;

    // Literal widths follow the instruction format
    assign lit_ext = lit_long_i
                   ? {6'h00, lit_i}                                     // R21
                   : {11'h000, lit_i[ea_pkg::LIT5_W-1:0]};
    assign op2_sel = (op2_src_i == ea_pkg::OP2_MEM) ? op2_mem_i :       // R15
                     (op2_src_i == ea_pkg::OP2_LIT) ? lit_ext : op2_reg_i;

    // Stack pointer register
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sp_ff <= ea_pkg::SP_RESET;
        end else begin
            sp_ff <= nxt_sp;
        end
    end

    // Limit deliberately has no reset term; contents undefined until written
    always_ff @(posedge mclk_i) begin
        if (limit_wr_i) begin
            limit_ff <= {limit_wdata_i[15:1], 1'b0};                    // R5 R6
        end
    end

    // Memory port stage
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mem_req_ff   <= 1'b0;
            mem_we_ff    <= 1'b0;
            ea_ff        <= 16'h0000;
            mem_wdata_ff <= 16'h0000;
        end else begin
            mem_req_ff   <= go;
            mem_we_ff    <= go && (is_push || (!is_stack && is_write_i));
            ea_ff        <= ea_calc;
            mem_wdata_ff <= push_word;
        end
    end

    // Write back stage
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wb_valid_ff <= 1'b0;
            wb_idx_ff   <= 4'h0;
            wb_data_ff  <= 16'h0000;
        end else begin
            wb_valid_ff <= wb_fire;
            wb_idx_ff   <= wb_idx;
            wb_data_ff  <= wb_data;
        end
    end

    // Operand and destination stage
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            op1_ff         <= 16'h0000;
            op2_ff         <= 16'h0000;
            dst_idx_ff     <= 4'h0;
            dst_is_default_working_reg_ff <= 1'b0;
        end else begin
            op1_ff         <= base_val_i;                               // R15
            op2_ff         <= op2_sel;
            dst_idx_ff     <= (mode_i == ea_pkg::MODE_FILE)
                              ? ea_pkg::WREG0_IDX : dst_idx_i;          // R14
            dst_is_default_working_reg_ff <= req_valid_i && (mode_i == ea_pkg::MODE_FILE) && dst_default_working_reg_i;
        end
    end

    // Trap and block pulses, level only for the cycle of the address
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            trap_ff  <= 1'b0;
            block_ff <= 1'b0;
        end else begin
            trap_ff  <= req_live && trap;                               // R22
            block_ff <= blocked && !trap;
        end
    end

    // Outputs straight from flops
    assign mem_req_o      = mem_req_ff;
    assign mem_we_o       = mem_we_ff;
    assign ea_o           = ea_ff;
    assign mem_wdata_o    = mem_wdata_ff;
    assign wb_valid_o     = wb_valid_ff;
    assign wb_idx_o       = wb_idx_ff;
    assign wb_data_o      = wb_data_ff;
    assign op1_o          = op1_ff;
    assign op2_o          = op2_ff;
    assign dst_idx_o      = dst_idx_ff;
    assign dst_is_default_working_reg_o  = dst_is_default_working_reg_ff;
    assign stack_trap_o   = trap_ff;
    assign secure_block_o = block_ff;
    assign sp_o           = sp_ff;

endmodule

// ==== test/ea_props.sv ====
`timescale 1ns/100ps
// Checks each result one cycle after the request that caused it
module ea_props (
    input wire logic               mclk_i,
    input wire logic               reset_i,
    input wire logic               req_valid_i,
    input wire ea_pkg::addr_mode_t mode_i,
    input wire logic [3:0]         ptr_idx_i,
    input wire logic [15:0]        ptr_val_i,
    input wire logic [15:0]        base_val_i,
    input wire logic [12:0]        file_addr_i,
    input wire logic [15:0]        wdata_i,
    input wire ea_pkg::stack_op_t  stack_op_i,
    input wire logic [6:0]         pc_hi_i,
    input wire logic [7:0]         status_low_byte_i,
    input wire logic               mem_req_o,
    input wire logic               mem_we_o,
    input wire logic [15:0]        ea_o,
    input wire logic [15:0]        mem_wdata_o,
    input wire logic               wb_valid_o,
    input wire logic               stack_trap_o,
    input wire logic               secure_block_o,
    input wire logic [15:0]        sp_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // Pointer request not overridden by a stack op; refused results are exempt
    wire gen_req = req_valid_i && stack_op_i == ea_pkg::STK_NONE && ptr_idx_i != 4'hf;
    wire refused = stack_trap_o || secure_block_o;
    push_order_a: assert property (stack_op_i == ea_pkg::STK_PUSH_DATA |=> refused ||
        (ea_o == $past(sp_o) && sp_o == $past(sp_o) + 16'h0002 && mem_we_o))
        else $error("push address or pointer step wrong");
    pop_order_a: assert property (stack_op_i == ea_pkg::STK_POP |=> refused ||
        (ea_o == $past(sp_o) - 16'h0002 && !mem_we_o)) else $error("pop address wrong");
    call_word_a: assert property (stack_op_i == ea_pkg::STK_PUSH_CALL |=> refused ||
        mem_wdata_o == {9'h000, $past(pc_hi_i)}) else $error("call push word wrong");
    exc_word_a: assert property (stack_op_i == ea_pkg::STK_PUSH_EXC |=> refused ||
        mem_wdata_o == {$past(status_low_byte_i), 1'b0, $past(pc_hi_i)})
        else $error("exception push word wrong");
    sp_aligned_a: assert property (sp_o[0] == 1'b0) else $error("stack pointer odd");
    floor_trap_a: assert property (stack_op_i == ea_pkg::STK_POP && sp_o == 16'h0800
        |=> stack_trap_o && !mem_req_o) else $error("underflow not trapped");
    trap_quiet_a: assert property (stack_trap_o |-> !mem_req_o && !wb_valid_o)
        else $error("trapped access still issued");
    ind_ea_a: assert property (gen_req && mode_i == ea_pkg::MODE_IND
        |=> ea_o == $past(ptr_val_i)) else $error("indirect address wrong");
    index_ea_a: assert property (gen_req && mode_i == ea_pkg::MODE_INDEXED
        |=> ea_o == $past(ptr_val_i) + $past(base_val_i)) else $error("indexed address wrong");
    file_ea_a: assert property (gen_req && mode_i == ea_pkg::MODE_FILE
        |=> ea_o == {3'h0, $past(file_addr_i)}) else $error("file address wrong");
endmodule

bind stack_limit_and_ea_generation ea_props u_ea_props (
    .mclk_i(mclk_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .mode_i(mode_i),
    .ptr_idx_i(ptr_idx_i), .ptr_val_i(ptr_val_i), .base_val_i(base_val_i),
    .file_addr_i(file_addr_i), .wdata_i(wdata_i), .stack_op_i(stack_op_i),
    .pc_hi_i(pc_hi_i), .status_low_byte_i(status_low_byte_i), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .ea_o(ea_o), .mem_wdata_o(mem_wdata_o), .wb_valid_o(wb_valid_o),
    .stack_trap_o(stack_trap_o), .secure_block_o(secure_block_o), .sp_o(sp_o)
);

// ==== test/dmem_model.sv ====
`timescale 1ns/100ps
// Word-wide data memory standing behind the address port
module dmem_model (
    input  wire logic        mclk_i,
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic [15:0] ea_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o
);
    logic [15:0] mem_ff [0:255];
    logic [15:0] junk_ff = 16'h5a5a;
    // Write lands at the edge that ends the access cycle
    always_ff @(posedge mclk_i) begin
        junk_ff <= ~junk_ff;
        if (mem_req_i && mem_we_i)
            mem_ff[ea_i[8:1]] <= wdata_i;
    end
    // Idle bus toggles so a stale word never passes for read data
    assign rdata_o = (mem_req_i && !mem_we_i) ? mem_ff[ea_i[8:1]] : junk_ff;
endmodule

// ==== test/stack_limit_and_ea_generation_tb.sv ====
`timescale 1ns/100ps
module stack_limit_and_ea_generation_tb;
    logic mclk_i, reset_i, req_valid_i, is_write_i, dst_default_working_reg_i, lit_long_i;
    logic sp_wr_i, limit_wr_i, boot_ram_en_i, secure_ram_en_i;
    logic [3:0] ptr_idx_i, dst_idx_i, wb_idx_o, dst_idx_o;
    logic [4:0] mod_const_i;
    logic [6:0] pc_hi_i;
    logic [7:0] status_low_byte_i;
    logic [9:0] lit_i;
    logic [12:0] file_addr_i;
    logic [15:0] ptr_val_i, base_val_i, lit_offset_i, wdata_i, op2_reg_i, op2_mem_i;
    logic [15:0] sp_wdata_i, limit_wdata_i, ea_o, mem_wdata_o, wb_data_o, op1_o, op2_o;
    logic [15:0] sp_o, rdata;
    logic mem_req_o, mem_we_o, wb_valid_o, dst_is_default_working_reg_o, stack_trap_o, secure_block_o;
    ea_pkg::addr_mode_t mode_i;
    ea_pkg::stack_op_t  stack_op_i;
    ea_pkg::op2_src_t   op2_src_i;
    ea_pkg::exec_seg_t  exec_seg_i;
    int mismatches = 0;
    int checks = 0;

    stack_limit_and_ea_generation u_stack_limit_and_ea_generation (.*);
    dmem_model u_dmem_model (.mclk_i(mclk_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
        .ea_i(ea_o), .wdata_i(mem_wdata_o), .rdata_o(rdata));

    // Clock at 50 ns
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    // Inputs move 2 ns after the edge so the next edge sees them settled
    task tick;
        @(posedge mclk_i);
        #2;
    endtask

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task t_reset;
        tick;
        chk("sp reset", 16'h0800, sp_o);
        chk("trap idle", 16'h0, stack_trap_o);
    endtask

    // Odd limit write must land even; the gap cycle keeps SP reads off it
    task t_limit;
        limit_wr_i = 1'b1;
        limit_wdata_i = 16'h0803;
        tick;
        limit_wr_i = 1'b0;
        tick;
        stack_op_i = ea_pkg::STK_PUSH_DATA;
        wdata_i = 16'h1111;
        tick;
        chk("push ea", 16'h0800, ea_o);
        chk("push wb", 16'h001f, {wb_valid_o, wb_idx_o});
        wdata_i = 16'h2222;
        tick;
        chk("push at limit", 16'h0, stack_trap_o);
        chk("sp up", 16'h0804, sp_o);
        tick;
        chk("push over", 16'h1, stack_trap_o);
        chk("sp held", 16'h0804, sp_o);
        stack_op_i = ea_pkg::STK_POP;
        tick;
        chk("pop ea", 16'h0802, ea_o);
        chk("pop data", 16'h2222, rdata);
        stack_op_i = ea_pkg::STK_NONE;
        req_valid_i = 1'b1;
        mode_i = ea_pkg::MODE_LITOFF;
        ptr_idx_i = 4'hf;
        lit_offset_i = 16'h0001;
        tick;
        chk("sp ea vs limit", 16'h1, stack_trap_o);
        req_valid_i = 1'b0;
        stack_op_i = ea_pkg::STK_POP;
        tick;
        chk("trap pulse", 16'h0, stack_trap_o);
        chk("pop data 2", 16'h1111, rdata);
        tick;
        chk("underflow", 16'h1, stack_trap_o);
        stack_op_i = ea_pkg::STK_NONE;
        sp_wr_i = 1'b1;
        sp_wdata_i = 16'h0901;
        tick;
        sp_wr_i = 1'b0;
        chk("sp even", 16'h0900, sp_o);
    endtask

    task t_words;
        limit_wr_i = 1'b1;
        limit_wdata_i = 16'h0ffe;
        tick;
        limit_wr_i = 1'b0;
        tick;
        stack_op_i = ea_pkg::STK_PUSH_CALL;
        pc_hi_i = 7'h7f;
        status_low_byte_i = 8'ha5;
        tick;
        chk("call word", 16'h007f, mem_wdata_o);
        stack_op_i = ea_pkg::STK_PUSH_EXC;
        tick;
        chk("exc word", 16'ha57f, mem_wdata_o);
        chk("exc ea", 16'h0902, ea_o);
        stack_op_i = ea_pkg::STK_NONE;
    endtask

    task t_modes;
        req_valid_i = 1'b1;
        ptr_idx_i = 4'h3;
        ptr_val_i = 16'h1234;
        base_val_i = 16'h0102;
        mod_const_i = 5'h1d;
        lit_offset_i = 16'h0040;
        mode_i = ea_pkg::MODE_IND;
        tick;
        chk("ind ea", 16'h1234, ea_o);
        chk("op1", 16'h0102, op1_o);
        mode_i = ea_pkg::MODE_POST;
        is_write_i = 1'b1;
        tick;
        chk("post ea", 16'h1234, ea_o);
        chk("post wb", 16'h1231, wb_data_o);
        chk("post wb ctl", 16'h0013, {wb_valid_o, wb_idx_o});
        chk("post write", 16'h0001, mem_we_o);
        chk("post wdata", 16'h2222, mem_wdata_o);
        is_write_i = 1'b0;
        mode_i = ea_pkg::MODE_PRE;
        tick;
        chk("pre ea", 16'h1231, ea_o);
        chk("pre wb", 16'h1231, wb_data_o);
        mode_i = ea_pkg::MODE_INDEXED;
        tick;
        chk("index ea", 16'h1336, ea_o);
        mode_i = ea_pkg::MODE_LITOFF;
        tick;
        chk("litoff ea", 16'h1274, ea_o);
        mode_i = ea_pkg::MODE_FILE;
        file_addr_i = 13'h1fff;
        dst_default_working_reg_i = 1'b1;
        tick;
        chk("file ea", 16'h1fff, ea_o);
        chk("file dst", 16'h0001, {dst_idx_o, dst_is_default_working_reg_o});
        mode_i = ea_pkg::MODE_DIRECT;
        dst_idx_i = 4'h5;
        tick;
        chk("direct no access", 16'h0, mem_req_o);
        chk("direct dst", 16'h000a, {dst_idx_o, dst_is_default_working_reg_o});
    endtask

    task t_ops;
        op2_src_i = ea_pkg::OP2_MEM;
        op2_mem_i = 16'h0b0b;
        tick;
        chk("op2 mem", 16'h0b0b, op2_o);
        op2_src_i = ea_pkg::OP2_LIT;
        lit_i = 10'h3ff;
        lit_long_i = 1'b1;
        tick;
        chk("lit long", 16'h03ff, op2_o);
        lit_long_i = 1'b0;
        tick;
        chk("lit short", 16'h001f, op2_o);
        op2_src_i = ea_pkg::OP2_DEFAULT_WORKING_REG;
        op2_reg_i = 16'h0a0a;
        tick;
        chk("op2 reg", 16'h0a0a, op2_o);
    endtask

    // Even cases come from a foreign segment and must be blocked
    task t_secure;
        boot_ram_en_i = 1'b1;
        secure_ram_en_i = 1'b1;
        mode_i = ea_pkg::MODE_IND;
        for (int i = 0; i < 4; i++) begin
            ptr_val_i = (i < 2) ? 16'h0810 : 16'h0890;
            exec_seg_i = ea_pkg::exec_seg_t'((i + 1) / 2);
            tick;
            chk("blocked", 16'((i + 1) % 2), secure_block_o);
            chk("allowed", 16'(i % 2), mem_req_o);
        end
        req_valid_i = 1'b0;
    endtask

    // Mid-run reset; the limit has no reset term and must survive it
    task t_rerun;
        {boot_ram_en_i, secure_ram_en_i, reset_i} = 3'h1;
        tick;
        reset_i = 1'b0;
        tick;
        chk("sp rerun", 16'h0800, sp_o);
        chk("trap rerun", 16'h0, stack_trap_o);
        stack_op_i = ea_pkg::STK_PUSH_DATA;
        tick;
        chk("limit kept", 16'h0, stack_trap_o);
        chk("push after reset", 16'h0800, ea_o);
        stack_op_i = ea_pkg::STK_NONE;
    endtask

    // Watchdog well beyond the few dozen cycles the tests take
    initial begin
        #50000;
        mismatches++;
        close_out;
    end

    initial begin
        {reset_i, req_valid_i, is_write_i, dst_default_working_reg_i, lit_long_i} = 5'h10;
        {sp_wr_i, limit_wr_i, boot_ram_en_i, secure_ram_en_i} = 4'h0;
        {ptr_idx_i, dst_idx_i, mod_const_i, pc_hi_i, status_low_byte_i} = 28'h0;
        {lit_i, file_addr_i, ptr_val_i, base_val_i, lit_offset_i} = 71'h0;
        {wdata_i, op2_reg_i, op2_mem_i, sp_wdata_i, limit_wdata_i} = 80'h0;
        mode_i = ea_pkg::MODE_FILE;
        stack_op_i = ea_pkg::STK_NONE;
        op2_src_i = ea_pkg::OP2_DEFAULT_WORKING_REG;
        exec_seg_i = ea_pkg::SEG_GENERAL;
        repeat (3) @(posedge mclk_i);
        #2;
        reset_i = 1'b0;
        t_reset;
        t_limit;
        t_words;
        t_modes;
        t_ops;
        t_secure;
        t_rerun;
        close_out;
    end
endmodule
